// file: logic/ipg_pkg.sv
`default_nettype none
package ipg_pkg;
  // Clock and timing base; the tick resolves 50 ms gate steps exactly
  localparam int CLK_NS      = 40;
  localparam int TICK_NS     = 1000000;
  localparam int TICK_CYC    = (TICK_NS + CLK_NS - 1) / CLK_NS;
  localparam int TICK_MS     = 1;
  localparam int STEP_MS     = 50;
  localparam int STEP_TICKS  = STEP_MS / TICK_MS;
  localparam int PULSE_MS    = 2;
  localparam int PULSE_TICKS = PULSE_MS / TICK_MS;
  // Widths and limits
  localparam int WORD_W      = 21;
  localparam int DLY_W       = 14;
  localparam int CNT_W       = 20;
  localparam int FIFO_DEPTH  = 8;
  localparam logic [21:0] BCD_MAX = 22'h030D3F;
  // Reset values
  localparam logic [7:0]  AUX_RST  = 8'h00;
  localparam logic [21:0] DOUT_RST = 22'h000000;
  localparam logic [1:0]  DC_RST   = 2'h0;

  typedef enum logic {FMT_TWOS, FMT_BCD} ipg_fmt_t;
  typedef enum logic [1:0] {SW_IDLE, SW_DELAY, SW_GATED} ipg_sw_t;

  // Parallel data word: sign line plus 21 data lines
  typedef struct packed {
    logic              sign;
    logic [WORD_W-1:0] word;
  } ipg_dio_t;

  // Program-control output connector
  typedef struct packed {
    logic dly_gate;
    logic reset;
    logic data_acq;
    logic trigger;
    logic undefined;
    logic sweep_gate;
    logic chan_a;
  } ipg_pcout_t;
endpackage
`default_nettype wire

// file: logic/ipg_top.sv
`default_nettype none
module ipg_top #(
  parameter int       TICK_CYCLES = ipg_pkg::TICK_CYC, // Clocks per 1 ms tick
  parameter logic     GATE_ACT    = 1'b1               // Active level of both gates
) (
  input  wire logic             clk,                       // 25 MHz clock
  input  wire logic             rst_n,                     // Async reset, active low
  input  wire ipg_pkg::ipg_dio_t din,                      // Digital input connector
  input  wire ipg_pkg::ipg_fmt_t din_fmt,                  // Input format
  output logic [21:0]           din_value,                 // Decoded signed value
  input  wire logic [21:0]      dout_value,                // Signed value to send
  input  wire ipg_pkg::ipg_fmt_t dout_fmt,                 // Output format
  input  wire logic             dout_wr,                   // Output word write strobe
  output ipg_pkg::ipg_dio_t     dout,                      // Digital output connector
  input  wire logic             sweep_start,               // Sweep begins (pulse)
  input  wire logic             sweep_end,                 // Sweep completes (pulse)
  input  wire logic [7:0]       gate_delay,                // Delay in 50 ms steps
  input  wire logic             settled,                   // Data settled (pulse)
  input  wire logic             settle_end,                // Settling delay over (pulse)
  input  wire logic             reset_req,                 // Reset line request level
  input  wire logic             chan_a,                    // Channel A measuring level
  output ipg_pkg::ipg_pcout_t   pc_out,                    // Program-control outputs
  input  wire logic [7:0]       pc_in,                     // Program-control input byte
  input  wire logic             pc_strobe,                 // Input byte present (pulse)
  input  wire logic             pc_pop,                    // Host takes one byte
  output logic [7:0]            pc_rdata,                  // Last byte taken
  output logic [3:0]            pc_count,                  // Bytes waiting
  output logic                  pc_ovf,                    // Byte lost, sticky
  input  wire logic             pc_ovf_clr,                // Clear overflow flag
  input  wire logic             aux_wr,                    // Auxiliary port write
  input  wire logic [1:0]       aux_sel,                   // Port select A..D
  input  wire logic [7:0]       aux_data,                  // Auxiliary write data
  output logic [7:0]            aux_a,                     // Auxiliary port A
  output logic [7:0]            aux_b,                     // Auxiliary port B
  output logic [7:0]            aux_c,                     // Auxiliary port C
  output logic [7:0]            aux_port_fourth_connector, // Auxiliary port D
  input  wire logic [1:0]       dc_en_wr,                  // Per-channel enable write
  input  wire logic [1:0]       dc_en_val,                 // Enable values
  output logic [1:0]            dc_en                      // DC channel enables
);
  import ipg_pkg::*;

  // Every check samples on the one clock and sleeps while reset is held
  default clocking dflt_cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  localparam logic [CNT_W-1:0] TICK_LAST = CNT_W'(TICK_CYCLES - 1);
  localparam logic [CNT_W-1:0] PULSE_CYC = CNT_W'(TICK_CYCLES * PULSE_TICKS);
  // BCD digits to binary magnitude; top digit has only its 1 line
  function automatic logic [21:0] bcd2bin(input logic [20:0] w);
    bcd2bin = 22'(w[3:0]) + 22'(w[7:4]) * 22'h00000A + 22'(w[11:8]) * 22'h000064
            + 22'(w[15:12]) * 22'h0003E8 + 22'(w[19:16]) * 22'h002710
            + 22'(w[20]) * 22'h0186A0;
  endfunction
  // Binary magnitude to BCD by shift-and-add-3, saturated to what fits
  function automatic logic [20:0] bin2bcd(input logic [21:0] m);
    logic [23:0] b;
    logic [21:0] s;
    b = 24'h000000;
    s = (m > BCD_MAX) ? BCD_MAX : m;
    for (int i = 21; i >= 0; i--) begin
      for (int d = 0; d < 6; d++) begin
        if (b[4*d +: 4] > 4'h4) b[4*d +: 4] = b[4*d +: 4] + 4'h3;
      end
      b = {b[22:0], s[i]};
    end
    bin2bcd = b[20:0];
  endfunction
  // Data words, auxiliary ports and DC enables
  logic [21:0] din_value_r, din_value_nxt, mag;
  ipg_dio_t    dout_r, dout_nxt;
  logic [7:0]  aux_r [4];
  logic [7:0]  aux_nxt [4];
  logic [1:0]  dc_en_r, dc_en_nxt;

  always_comb begin
    mag = dout_value[21] ? 22'(-dout_value) : dout_value;
    if (din_fmt == FMT_BCD) begin
      din_value_nxt = din.sign ? 22'(-bcd2bin(din.word)) : bcd2bin(din.word);
    end else begin
      din_value_nxt = {din.sign, din.word};
    end
    dout_nxt = dout_r;
    if (dout_wr) begin
      if (dout_fmt == FMT_BCD) begin
        dout_nxt = '{sign: dout_value[21], word: bin2bcd(mag)};
      end else begin
        dout_nxt = '{sign: dout_value[21], word: dout_value[20:0]};
      end
    end
    for (int i = 0; i < 4; i++) begin
      aux_nxt[i] = aux_r[i];
      if (aux_wr && aux_sel == 2'(i)) aux_nxt[i] = aux_data;
    end
    dc_en_nxt = (dc_en_r & ~dc_en_wr) | (dc_en_val & dc_en_wr);
  end
  // Data registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      din_value_r <= DOUT_RST;
      dout_r      <= DOUT_RST;
      aux_r       <= '{AUX_RST, AUX_RST, AUX_RST, AUX_RST};
      dc_en_r     <= DC_RST;
    end else begin
      din_value_r <= din_value_nxt;
      dout_r      <= dout_nxt;
      aux_r       <= aux_nxt;
      dc_en_r     <= dc_en_nxt;
    end
  end
  assign din_value                 = din_value_r;
  assign dout                      = dout_r;
  assign aux_a                     = aux_r[0];
  assign aux_b                     = aux_r[1];
  assign aux_c                     = aux_r[2];
  assign aux_port_fourth_connector = aux_r[3];
  assign dc_en                     = dc_en_r;
  property p_dout_twos;
    dout_wr && dout_fmt == FMT_TWOS |=> dout == $past(dout_value);
  endproperty
  a_dout_twos: assert property (p_dout_twos) else $error("output word mismatch");
  property p_aux;
    aux_wr && aux_sel == 2'h3 |=> aux_port_fourth_connector == $past(aux_data) && $stable(aux_a);
  endproperty
  a_aux: assert property (p_aux) else $error("aux port write wrong");
  property p_dc;
    dc_en_wr == 2'h1 |=> $stable(dc_en[1]) && dc_en[0] == $past(dc_en_val[0]);
  endproperty
  a_dc: assert property (p_dc) else $error("dc enables coupled");

  // Sweep gate sequencer; the tick divider restarts at sweep start so the
  // delayed edge lands exactly on a 50 ms boundary
  ipg_sw_t          sw_r, sw_nxt;
  logic [CNT_W-1:0] tick_r, tick_nxt;
  logic [DLY_W-1:0] dly_r, dly_nxt;
  logic [7:0]       steps;
  logic             tick;

  always_comb begin
    tick     = (tick_r == TICK_LAST);
    tick_nxt = tick ? '0 : tick_r + 1'b1;
    steps    = (gate_delay == 8'h00) ? 8'h01 : gate_delay;
    sw_nxt   = sw_r;
    dly_nxt  = dly_r;
    case (sw_r)
      SW_IDLE: begin
        if (sweep_start) sw_nxt = SW_DELAY;
      end
      SW_DELAY: begin
        if (sweep_end) begin
          sw_nxt = SW_IDLE;
        end else if (tick && dly_r == DLY_W'(1)) begin
          sw_nxt = SW_GATED;
        end else if (tick) begin
          dly_nxt = dly_r - 1'b1;
        end
      end
      SW_GATED: begin
        if (sweep_end) sw_nxt = SW_IDLE;
      end
      default: sw_nxt = SW_IDLE;
    endcase
    // A new start always wins and restarts the delay from zero
    if (sweep_start) begin
      sw_nxt   = SW_DELAY;
      tick_nxt = '0;
      dly_nxt  = DLY_W'(steps) * DLY_W'(STEP_TICKS);
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sw_r   <= SW_IDLE;
      tick_r <= '0;
      dly_r  <= '0;
    end else begin
      sw_r   <= sw_nxt;
      tick_r <= tick_nxt;
      dly_r  <= dly_nxt;
    end
  end
  property p_gate_start;
    sweep_start |=> pc_out.sweep_gate == GATE_ACT && pc_out.dly_gate != GATE_ACT;
  endproperty
  a_gate_start: assert property (p_gate_start) else $error("gate start wrong");
  property p_gate_end;
    sweep_end && !sweep_start |=> pc_out.sweep_gate != GATE_ACT && pc_out.dly_gate != GATE_ACT;
  endproperty
  a_gate_end: assert property (p_gate_end) else $error("gate not released");
  property p_dly_hold;
    $rose(pc_out.dly_gate == GATE_ACT) |-> $past(tick) && $past(dly_r) == DLY_W'(1);
  endproperty
  a_dly_hold: assert property (p_dly_hold) else $error("delayed gate early");

  // Pulse timers count whole clock cycles of two ticks so width is exact,
  // not one to two ticks as a tick-aligned count would give
  logic [CNT_W-1:0] acq_r, acq_nxt, trg_r, trg_nxt;
  ipg_pcout_t       pc_r, pc_nxt;

  always_comb begin
    acq_nxt = (acq_r != '0) ? acq_r - 1'b1 : acq_r;
    trg_nxt = (trg_r != '0) ? trg_r - 1'b1 : trg_r;
    if (settled) acq_nxt = PULSE_CYC;
    if (settle_end) trg_nxt = PULSE_CYC;
    pc_nxt.sweep_gate = (sw_nxt != SW_IDLE) ? GATE_ACT : ~GATE_ACT;
    pc_nxt.dly_gate   = (sw_nxt == SW_GATED) ? GATE_ACT : ~GATE_ACT;
    pc_nxt.data_acq   = (acq_nxt != '0);
    pc_nxt.trigger    = (trg_nxt != '0);
    pc_nxt.reset      = reset_req;
    pc_nxt.chan_a     = chan_a;
    pc_nxt.undefined  = 1'b0;
  end
  // Reset line reads high straight after power-up, as the far end expects
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acq_r <= '0;
      trg_r <= '0;
      pc_r  <= '{dly_gate: ~GATE_ACT, reset: 1'b1, sweep_gate: ~GATE_ACT, default: 1'b0};
    end else begin
      acq_r <= acq_nxt;
      trg_r <= trg_nxt;
      pc_r  <= pc_nxt;
    end
  end
  assign pc_out = pc_r;
  property p_acq;
    settled |=> pc_out.data_acq [*8];
  endproperty
  a_acq: assert property (p_acq) else $error("data acquired pulse short");
  property p_trg_end;
    $fell(pc_out.trigger) |-> $past(trg_r) == CNT_W'(1);
  endproperty
  a_trg_end: assert property (p_trg_end) else $error("trigger width wrong");

  // Program-control input FIFO; a byte arriving while full with no pop in that cycle is dropped and flagged
  logic [7:0] fifo_mem [FIFO_DEPTH];
  logic [2:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic       ovf_r, ovf_nxt, push, pop;

  always_comb begin
    pop       = pc_pop && (cnt_r != 4'h0);
    push      = pc_strobe && ((cnt_r != 4'(FIFO_DEPTH)) || pop);
    wp_nxt    = push ? wp_r + 1'b1 : wp_r;
    rp_nxt    = pop ? rp_r + 1'b1 : rp_r;
    cnt_nxt   = cnt_r + 4'(push) - 4'(pop);
    rdata_nxt = pop ? fifo_mem[rp_r] : rdata_r;
    // Set wins over clear so a loss in the clearing cycle still shows
    ovf_nxt   = (pc_strobe && !push) || (ovf_r && !pc_ovf_clr);
  end
  always_ff @(posedge clk) begin
    if (push) fifo_mem[wp_r] <= pc_in;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_r    <= '0;
      rp_r    <= '0;
      cnt_r   <= '0;
      rdata_r <= 8'h00;
      ovf_r   <= 1'b0;
    end else begin
      wp_r    <= wp_nxt;
      rp_r    <= rp_nxt;
      cnt_r   <= cnt_nxt;
      rdata_r <= rdata_nxt;
      ovf_r   <= ovf_nxt;
    end
  end
  assign pc_rdata = rdata_r;
  assign pc_count = cnt_r;
  assign pc_ovf   = ovf_r;
  property p_fifo;
    pc_strobe && pc_count < 4'(FIFO_DEPTH) |=> pc_count <= 4'(FIFO_DEPTH) && !$rose(pc_ovf);
  endproperty
  a_fifo: assert property (p_fifo) else $error("fifo count or loss wrong");
endmodule
`default_nettype wire

// file: tb/ipg_ext_model.sv
`default_nettype none
// Far-side test equipment: presents words and program-control bytes
module ipg_ext_model
  import ipg_pkg::*;
(
  input  wire logic clk,       // Bench clock
  output ipg_dio_t  din,       // Word on the input connector
  output logic [7:0] pc_in,    // Program-control byte lines
  output logic      pc_strobe  // Byte present pulse
);
  timeunit 1ns;
  timeprecision 1ns;

  // Signed value to connector bits; BCD magnitude clips at 199999
  function automatic logic [21:0] enc(input logic [21:0] v, input logic bcd);
    int          m;
    logic [21:0] r;
    m = $signed(v);
    if (!bcd) return v;
    if (m < 0) m = -m;
    if (m > 199999) m = 199999;
    r = {v[21], 21'h000000};
    for (int i = 0; i < 5; i++) begin
      r[4*i+:4] = 4'(m % 10);
      m = m / 10;
    end
    r[20] = m[0];
    return r;
  endfunction

  // Word changes only on the falling edge, away from sampling
  task automatic put_word(input logic [21:0] v, input logic bcd);
    @(negedge clk);
    din <= enc(v, bcd);
  endtask

  // One byte, then the lines leave the old value so nothing stale is read
  task automatic send_byte(input logic [7:0] b);
    @(negedge clk);
    pc_in     <= b;
    pc_strobe <= 1'b1;
    @(negedge clk);
    pc_in     <= ~b;
    pc_strobe <= 1'b0;
  endtask

  // Idle lines at time zero
  initial begin
    din       = '0;
    pc_in     = 8'h00;
    pc_strobe = 1'b0;
  end
endmodule
`default_nettype wire

// file: tb/ipg_top_tb.sv
`default_nettype none
module ipg_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import ipg_pkg::*;
  // Short tick keeps the 50 ms steps at 200 cycles
  localparam int TC   = 4;
  localparam int STEP = STEP_TICKS * TC;
  localparam int PW   = PULSE_TICKS * TC;

  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  ipg_dio_t    din, dout;
  ipg_fmt_t    din_fmt, dout_fmt;
  ipg_pcout_t  pc_out;
  logic [21:0] din_value, dout_value, v, e;
  logic        dout_wr, sweep_start, sweep_end, settled, settle_end, reset_req, chan_a;
  logic [7:0]  gate_delay, pc_in, pc_rdata, aux_data, aux_a, aux_b, aux_c, aux_d;
  logic        pc_strobe, pc_pop, pc_ovf, pc_ovf_clr, aux_wr;
  logic [3:0]  pc_count;
  logic [1:0]  aux_sel, dc_en_wr, dc_en_val, dc_en, de;
  logic [7:0]  ea [4];
  logic [7:0]  q [$];
  logic [21:0] corner [4] = '{22'h030D40, 22'h3CF2C0, 22'h200000, 22'h1FFFFF};
  integer      seed = 32'h690cd385;
  int          fail_count = 0;
  int          checks = 0;
  int          n;

  always #20 clk = ~clk;

  ipg_ext_model u_ext (.clk, .din, .pc_in, .pc_strobe);

  ipg_top #(.TICK_CYCLES(TC)) u_dut (
    .clk, .rst_n, .din, .din_fmt, .din_value, .dout_value, .dout_fmt, .dout_wr, .dout,
    .sweep_start, .sweep_end, .gate_delay, .settled, .settle_end, .reset_req, .chan_a,
    .pc_out, .pc_in, .pc_strobe, .pc_pop, .pc_rdata, .pc_count, .pc_ovf, .pc_ovf_clr,
    .aux_wr, .aux_sel, .aux_data, .aux_a, .aux_b, .aux_c, .aux_port_fourth_connector(aux_d),
    .dc_en_wr, .dc_en_val, .dc_en
  );

  // Value comparison
  task automatic chk(input logic [21:0] got, input logic [21:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Cycle count comparison
  task automatic chk_n(input int got, input int exp);
    checks++;
    if (got != exp) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Single-cycle strobe, launched and dropped on falling edges
  task automatic pulse(ref logic s);
    @(negedge clk);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
  endtask

  task automatic stop_test;
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Watchdog: a hang counts as a mismatch
  initial begin
    repeat (100000) @(posedge clk);
    fail_count++;
    stop_test();
  end

  // Main sequence
  initial begin
    {dout_value, dout_wr, sweep_start, sweep_end, gate_delay, settled, settle_end, reset_req,
     chan_a, pc_pop, pc_ovf_clr, aux_wr, aux_sel, aux_data, dc_en_wr, dc_en_val} = '0;
    din_fmt  = FMT_TWOS;
    dout_fmt = FMT_TWOS;
    de = 2'h0;
    foreach (ea[i]) ea[i] = AUX_RST;
    repeat (5) @(negedge clk);
    chk({pc_out.reset, pc_out.sweep_gate, pc_out.dly_gate}, 22'h000004);
    chk(dout, DOUT_RST);
    rst_n = 1'b1;
    // Input decode in both formats, BCD kept inside six digits
    for (int i = 0; i < 20; i++) begin
      n = $unsigned($random(seed)) % 200000;
      v = i[0] ? 22'(($random(seed) & 1) ? -n : n) : 22'($random(seed));
      u_ext.put_word(v, i[0]);
      din_fmt = ipg_fmt_t'(i[0]);
      @(negedge clk);
      chk(din_value, v);
    end
    // Back-to-back output writes, corners first, as a sweep would give them
    for (int i = 0; i < 24; i++) begin
      v = (i < 4) ? corner[i] : (i[0] ? 22'($random(seed) % 200000) : 22'($random(seed)));
      @(negedge clk);
      if (i > 0) chk(dout, e);
      dout_value = v;
      dout_fmt = ipg_fmt_t'(i[0]);
      dout_wr = 1'b1;
      e = u_ext.enc(v, i[0]);
    end
    @(negedge clk);
    chk(dout, e);
    dout_wr = 1'b0;
    repeat (3) @(negedge clk);
    chk(dout, e);
    // Sweeps with zero (taken as one), one and two delay steps
    for (int d = 0; d <= 2; d++) begin
      gate_delay = 8'(d);
      pulse(sweep_start);
      chk({pc_out.sweep_gate, pc_out.dly_gate}, 22'h000002);
      n = 0;
      while (pc_out.dly_gate !== 1'b1 && n < 1000) begin
        @(negedge clk);
        n++;
      end
      if (n >= 1000) begin
        fail_count++;
        stop_test();
      end
      chk_n(n, (d > 0 ? d : 1) * STEP);
      pulse(sweep_end);
      chk({pc_out.sweep_gate, pc_out.dly_gate}, 22'h000000);
    end
    // Data-acquired and trigger pulse widths
    for (int p = 0; p < 2; p++) begin
      if (p == 0) pulse(settled);
      else pulse(settle_end);
      n = 0;
      while ((p ? pc_out.trigger : pc_out.data_acq) === 1'b1 && n < 100) begin
        @(negedge clk);
        n++;
      end
      if (n >= 100) begin
        fail_count++;
        stop_test();
      end
      chk_n(n, PW);
    end
    // Fill past eight bytes, then drain and pop once more while empty
    for (int i = 0; i < 9; i++) begin
      q.push_back(8'($random(seed)));
      u_ext.send_byte(q[i]);
    end
    @(negedge clk);
    chk({pc_count, pc_ovf}, {4'h8, 1'b1});
    pulse(pc_ovf_clr);
    chk(pc_ovf, 1'b0);
    for (int i = 0; i < 8; i++) begin
      pulse(pc_pop);
      chk(pc_rdata, q[i]);
    end
    pulse(pc_pop);
    chk({pc_count, pc_rdata}, {4'h0, q[7]});
    // Random port writes; the other ports must hold and the reset and channel A levels follow their inputs
    for (int i = 0; i < 24; i++) begin
      @(negedge clk);
      {aux_sel, aux_data, dc_en_wr, dc_en_val, reset_req, chan_a} = 16'($random(seed));
      aux_wr = 1'b1;
      ea[aux_sel] = aux_data;
      de = (de & ~dc_en_wr) | (dc_en_val & dc_en_wr);
      @(negedge clk);
      aux_wr = 1'b0;
      dc_en_wr = 2'h0;
      chk({aux_b, aux_a}, {ea[1], ea[0]});
      chk({aux_d, aux_c}, {ea[3], ea[2]});
      chk(dc_en, de);
      chk({pc_out.reset, pc_out.chan_a, pc_out.undefined}, {reset_req, chan_a, 1'b0});
    end
    stop_test();
  end
endmodule
`default_nettype wire
